// file: temp_offset_and_overtemp_fan_regs_tb.sv
// testbench: self-checking bench of the offset and overtemp fan behaviour registers
`default_nettype none
module temp_offset_and_overtemp_fan_regs_tb
  import tofr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // signals and constants
  // ------------------------------------------------------------
  localparam logic [3:0] REV        = 4'h6;  // arbitrary value
  localparam int         TIME_LIMIT = 3000;
  localparam logic [7:0] OFS_ADDR [3] = '{TOFR_ADDR_LOCAL_OFS, TOFR_ADDR_R1_OFS, TOFR_ADDR_R2_OFS};
  localparam logic [7:0] OFS_VAL  [4] = '{8'hFF, 8'h0F, 8'h85, 8'h7A};
  logic                  core_clk;
  logic                  rst;
  tofr_req_t             reg_req;
  wire logic [7:0]       reg_rdata;
  logic                  overtemp_n;
  wire logic             fan_full_speed;
  logic [2:0][10:0]      raw_v;
  wire logic [2:0][10:0] adj_v;
  logic [7:0]            rd_v;
  logic [10:0]           exp_v;
  int                    err_count;
  int                    n_tests;
  int                    cycles;

  tofr_regs #(.TEMP_W(11), .FRAC_W(3), .REVISION(REV)) uut (
    .core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .overtemp_n(overtemp_n), .fan_full_speed(fan_full_speed),
    .local_raw(raw_v[0]), .remote1_raw(raw_v[1]), .remote2_raw(raw_v[2]),
    .local_adj(adj_v[0]), .remote1_adj(adj_v[1]), .remote2_adj(adj_v[2]));

  // clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == TIME_LIMIT)
    begin
      err_count++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    reg_req <= '0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_edges(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // offset applied in whole degrees of 8 fraction steps, clipped at range ends
  function automatic logic [10:0] exp_adj(input int r, input logic [7:0] o);
    int v;
    v = o[7] ? r - int'(o[3:0]) * 8 : r + int'(o[3:0]) * 8;
    if (v > 1023) v = 1023;
    if (v < -1024) v = -1024;
    exp_adj = v[10:0];
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset();
    reg_write(8'h20, 8'hFF);
    for (int i = 0; i < 3; i++)
    begin
      reg_read(OFS_ADDR[i], rd_v);
      check({3'h0, rd_v}, 11'h000);
      check(adj_v[i], raw_v[i]);
    end
    reg_read(TOFR_ADDR_BEHAV, rd_v);
    check({3'h0, rd_v}, {3'h0, 1'b1, 3'h0, REV});
    reg_read(8'h20, rd_v);
    check({3'h0, rd_v}, 11'h000);
    $display("test reset values done");
  endtask

  task automatic test_fan();
    @(posedge core_clk);
    overtemp_n <= 1'b0;
    wait_edges(2);
    check({10'h0, fan_full_speed}, 11'h001);
    wait_edges(6);
    check({10'h0, fan_full_speed}, 11'h001);
    @(posedge core_clk);
    overtemp_n <= 1'b1;
    wait_edges(2);
    check({10'h0, fan_full_speed}, 11'h000);
    reg_write(TOFR_ADDR_BEHAV, 8'h0F);
    reg_read(TOFR_ADDR_BEHAV, rd_v);
    check({3'h0, rd_v}, {7'h00, REV});
    @(posedge core_clk);
    overtemp_n <= 1'b0;
    wait_edges(4);
    check({10'h0, fan_full_speed}, 11'h000);
    reg_write(TOFR_ADDR_BEHAV, 8'h80);
    wait_edges(2);
    check({10'h0, fan_full_speed}, 11'h001);
    @(posedge core_clk);
    overtemp_n <= 1'b1;
    $display("test overtemp fan behaviour done");
  endtask

  task automatic test_offsets();
    for (int i = 0; i < 3; i++)
      for (int k = 0; k < 4; k++)
      begin
        reg_write(OFS_ADDR[i], OFS_VAL[k]);
        reg_read(OFS_ADDR[i], rd_v);
        check({3'h0, rd_v}, {3'h0, OFS_VAL[k][7], 3'h0, OFS_VAL[k][3:0]});
        wait_edges(2);
        exp_v = exp_adj(int'($signed(raw_v[i])), OFS_VAL[k]);
        check(adj_v[i], exp_v);
      end
    // adjusted value follows a new reading, clipped at the top of the range
    @(posedge core_clk);
    raw_v[0] <= 11'sd1000;
    wait_edges(3);
    check(adj_v[0], exp_adj(1000, OFS_VAL[3]));
    // subtracting from the same raw reading of 1000 must move the adjusted value off the top again
    reg_write(OFS_ADDR[0], 8'h8F);
    wait_edges(3);
    check(adj_v[0], exp_adj(1000, 8'h8F));
    $display("test offset registers done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    core_clk   = 1'b0;
    rst        = 1'b1;
    reg_req    = '0;
    overtemp_n = 1'b1;
    raw_v      = {11'sd37, -11'sd100, 11'sd200};
    err_count  = 0;
    n_tests    = 0;
    cycles     = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    test_reset();
    test_fan();
    test_offsets();
    complete_run();
  end
endmodule
`default_nettype wire

// file: tofr_offset_adder.sv
// module: applies a signed one-degree-step offset to a temperature reading
`default_nettype none
module tofr_offset_adder
  import tofr_pkg::*;
#(
  parameter int TEMP_W = 11,
  parameter int FRAC_W = 3
)(
  input  wire logic                     core_clk,  // core clock
  input  wire logic                     rst,       // async reset, high
  input  wire logic signed [TEMP_W-1:0] temp_raw,  // raw reading
  input  wire logic [7:0]               ofs_reg,   // offset register
  output logic signed [TEMP_W-1:0]      temp_adj   // adjusted reading
);

  logic signed [TEMP_W:0]   ext_w;
  logic signed [TEMP_W:0]   dlt_w;
  logic signed [TEMP_W:0]   sum_w;
  logic                     ovf_w;
  logic signed [TEMP_W-1:0] sat_w;
  logic signed [TEMP_W-1:0] adj_q;

  // ------------------------------------------------------------
  // add or subtract the magnitude, scaled to whole degrees
  // ------------------------------------------------------------
  assign ext_w = {temp_raw[TEMP_W-1], temp_raw};
  assign dlt_w = {{(TEMP_W+1-TOFR_MAG_W-FRAC_W){1'b0}}, ofs_reg[TOFR_MAG_W-1:0],
                  {FRAC_W{1'b0}}};
  assign sum_w = ofs_reg[TOFR_SIGN_BIT] ? (ext_w - dlt_w) : (ext_w + dlt_w);
  // clamp instead of wrapping at the range ends
  assign ovf_w = sum_w[TEMP_W] != sum_w[TEMP_W-1];
  assign sat_w = ovf_w ? {sum_w[TEMP_W], {(TEMP_W-1){~sum_w[TEMP_W]}}}
                       : sum_w[TEMP_W-1:0];

  // registered result
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      adj_q <= '0;
    else
      adj_q <= sat_w;
  end

  assign temp_adj = adj_q;

endmodule
`default_nettype wire

// file: tofr_pkg.sv
// package: register map, field layout and reset values of the temperature offset registers
`default_nettype none
package tofr_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] TOFR_ADDR_LOCAL_OFS = 8'h0D;
  localparam logic [7:0] TOFR_ADDR_R1_OFS    = 8'h0E;
  localparam logic [7:0] TOFR_ADDR_R2_OFS    = 8'h0F;
  localparam logic [7:0] TOFR_ADDR_BEHAV     = 8'h3F;

  // ------------------------------------------------------------
  // field positions and widths
  // ------------------------------------------------------------
  localparam int         TOFR_SIGN_BIT   = 7;
  localparam int         TOFR_FAN_EN_BIT = 7;
  localparam int         TOFR_MAG_W      = 4;
  localparam logic [2:0] TOFR_UNUSED_VAL = 3'h0;
  localparam logic [2:0] TOFR_BEHAV_GAP  = 3'h0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] TOFR_RST_OFS    = 8'h00;
  localparam logic       TOFR_RST_FAN_EN = 1'b1;
  localparam logic [7:0] TOFR_RD_UNMAP   = 8'h00;

  // register access request from the serial bus interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tofr_req_t;

  // keep sign and magnitude, force the unused bits to zero
  function automatic logic [7:0] tofr_pack_offset(input logic [7:0] wdata);
    tofr_pack_offset = {wdata[TOFR_SIGN_BIT], TOFR_UNUSED_VAL, wdata[TOFR_MAG_W-1:0]};
  endfunction

endpackage
`default_nettype wire

// file: tofr_regs.sv
// module: temperature offset registers and overtemp-to-fan behaviour register
// Function
// - enable bit forces fans full while overtemp
// - enable cleared: overtemp leaves fans alone
// - enable bit resets to one
// - low nibble reads revision, writes ignored
// - local sign: zero adds, one subtracts
// - local magnitude bits 3:0, up to 15
// - remote 1 sign: zero adds, one subtracts
// - remote bits 6:4 read zero
// - remote 1 magnitude bits 3:0, up to 15
// - remote 2 sign: zero adds, one subtracts
// - remote 2 magnitude bits 3:0, up to 15
// - offset registers reset to zero
`default_nettype none
module tofr_regs
  import tofr_pkg::*;
#(
  parameter int         TEMP_W   = 11,
  parameter int         FRAC_W   = 3,
  parameter logic [3:0] REVISION = 4'h1  // arbitrary value
)(
  input  wire logic                     core_clk,       // core clock
  input  wire logic                     rst,            // async reset, high
  input  wire tofr_req_t                reg_req,        // register access
  output logic [7:0]                    reg_rdata,      // read data, next cycle
  input  wire logic                     overtemp_n,     // overtemp output level, low
  output logic                          fan_full_speed, // force fans to full
  input  wire logic signed [TEMP_W-1:0] local_raw,      // local raw reading
  input  wire logic signed [TEMP_W-1:0] remote1_raw,    // remote 1 raw reading
  input  wire logic signed [TEMP_W-1:0] remote2_raw,    // remote 2 raw reading
  output logic signed [TEMP_W-1:0]      local_adj,      // local adjusted
  output logic signed [TEMP_W-1:0]      remote1_adj,    // remote 1 adjusted
  output logic signed [TEMP_W-1:0]      remote2_adj     // remote 2 adjusted
);

  logic [7:0] local_temp_offset_q;
  logic [7:0] remote1_temp_offset_q;
  logic [7:0] remote2_temp_offset_q;
  logic       full_speed_on_overtemp_enable_q;
  logic       fan_full_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] behav_w;
  logic       wr_local_w;
  logic       wr_r1_w;
  logic       wr_r2_w;
  logic       wr_behav_w;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign wr_local_w = reg_req.wr && (reg_req.addr == TOFR_ADDR_LOCAL_OFS);
  assign wr_r1_w    = reg_req.wr && (reg_req.addr == TOFR_ADDR_R1_OFS);
  assign wr_r2_w    = reg_req.wr && (reg_req.addr == TOFR_ADDR_R2_OFS);
  assign wr_behav_w = reg_req.wr && (reg_req.addr == TOFR_ADDR_BEHAV);

  // behaviour register image: revision is a constant, not storage
  assign behav_w = {full_speed_on_overtemp_enable_q, TOFR_BEHAV_GAP, REVISION};

  // read mux, unmapped addresses answer zero
  always_comb
  begin
    if (reg_req.addr == TOFR_ADDR_LOCAL_OFS)
      rdata_d = local_temp_offset_q;
    else if (reg_req.addr == TOFR_ADDR_R1_OFS)
      rdata_d = remote1_temp_offset_q;
    else if (reg_req.addr == TOFR_ADDR_R2_OFS)
      rdata_d = remote2_temp_offset_q;
    else if (reg_req.addr == TOFR_ADDR_BEHAV)
      rdata_d = behav_w;
    else
      rdata_d = TOFR_RD_UNMAP;
  end

  // ------------------------------------------------------------
  // offset registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      local_temp_offset_q   <= TOFR_RST_OFS;
      remote1_temp_offset_q <= TOFR_RST_OFS;
      remote2_temp_offset_q <= TOFR_RST_OFS;
    end
    else
    begin
      if (wr_local_w)
        local_temp_offset_q <= tofr_pack_offset(reg_req.wdata);
      if (wr_r1_w)
        remote1_temp_offset_q <= tofr_pack_offset(reg_req.wdata);
      if (wr_r2_w)
        remote2_temp_offset_q <= tofr_pack_offset(reg_req.wdata);
    end
  end

  // behaviour bit; only bit 7 is writable
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      full_speed_on_overtemp_enable_q <= TOFR_RST_FAN_EN;
    else if (wr_behav_w)
      full_speed_on_overtemp_enable_q <= reg_req.wdata[TOFR_FAN_EN_BIT];
  end

  // read data register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata_q <= TOFR_RD_UNMAP;
    else if (reg_req.rd)
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;

  // ------------------------------------------------------------
  // overtemp to fan forcing
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fan_full_q <= 1'b0;
    else
      fan_full_q <= full_speed_on_overtemp_enable_q && !overtemp_n;
  end

  assign fan_full_speed = fan_full_q;

  // ------------------------------------------------------------
  // offset application per channel
  // ------------------------------------------------------------
  // adjusted values go on to reading registers and limit logic
  tofr_offset_adder #(.TEMP_W(TEMP_W), .FRAC_W(FRAC_W)) u_local (
    .core_clk (core_clk),
    .rst      (rst),
    .temp_raw (local_raw),
    .ofs_reg  (local_temp_offset_q),
    .temp_adj (local_adj)
  );

  tofr_offset_adder #(.TEMP_W(TEMP_W), .FRAC_W(FRAC_W)) u_remote1 (
    .core_clk (core_clk),
    .rst      (rst),
    .temp_raw (remote1_raw),
    .ofs_reg  (remote1_temp_offset_q),
    .temp_adj (remote1_adj)
  );

  tofr_offset_adder #(.TEMP_W(TEMP_W), .FRAC_W(FRAC_W)) u_remote2 (
    .core_clk (core_clk),
    .rst      (rst),
    .temp_raw (remote2_raw),
    .ofs_reg  (remote2_temp_offset_q),
    .temp_adj (remote2_adj)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // first cycle after reset release
  logic seen_q;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      seen_q <= 1'b0;
    else
      seen_q <= 1'b1;
  end

  sequence overtemp_enabled_s;
    full_speed_on_overtemp_enable_q && !overtemp_n;
  endsequence

  full_speed_a: assert property (overtemp_enabled_s |=> fan_full_speed)
    else $error("fans not forced full during overtemp");
  quiet_mode_a: assert property (!full_speed_on_overtemp_enable_q |=> !fan_full_speed)
    else $error("fans forced full with enable cleared");
  enable_reset_a: assert property (!seen_q |-> full_speed_on_overtemp_enable_q)
    else $error("enable bit not one after reset");
  revision_ro_a: assert property (reg_req.rd && reg_req.addr == TOFR_ADDR_BEHAV
    |=> reg_rdata[3:0] == REVISION)
    else $error("revision nibble wrong");
  // direction checks skip the release edge, where the adjusted value is still the reset zero
  local_add_a: assert property (seen_q && !local_temp_offset_q[TOFR_SIGN_BIT]
    |=> local_adj >= $past(local_raw))
    else $error("local offset not added");
  local_sub_a: assert property (seen_q && local_temp_offset_q[TOFR_SIGN_BIT]
    |=> local_adj <= $past(local_raw))
    else $error("local offset not subtracted");
  local_mag_a: assert property (wr_local_w
    |=> local_temp_offset_q[3:0] == $past(reg_req.wdata[3:0]))
    else $error("local magnitude not stored");
  remote1_dir_a: assert property (seen_q && remote1_temp_offset_q[TOFR_SIGN_BIT]
    |=> remote1_adj <= $past(remote1_raw))
    else $error("remote 1 offset not subtracted");
  remote1_add_a: assert property (seen_q && !remote1_temp_offset_q[TOFR_SIGN_BIT]
    |=> remote1_adj >= $past(remote1_raw))
    else $error("remote 1 offset not added");
  unused_zero_a: assert property (reg_req.rd
    && (reg_req.addr == TOFR_ADDR_R1_OFS || reg_req.addr == TOFR_ADDR_R2_OFS)
    |=> reg_rdata[6:4] == 3'h0)
    else $error("unused remote bits not zero");
  remote1_mag_a: assert property (wr_r1_w
    |=> remote1_temp_offset_q[3:0] == $past(reg_req.wdata[3:0]))
    else $error("remote 1 magnitude not stored");
  remote2_dir_a: assert property (seen_q && remote2_temp_offset_q[TOFR_SIGN_BIT]
    |=> remote2_adj <= $past(remote2_raw))
    else $error("remote 2 offset not subtracted");
  remote2_add_a: assert property (seen_q && !remote2_temp_offset_q[TOFR_SIGN_BIT]
    |=> remote2_adj >= $past(remote2_raw))
    else $error("remote 2 offset not added");
  remote2_mag_a: assert property (wr_r2_w
    |=> remote2_temp_offset_q[3:0] == $past(reg_req.wdata[3:0]))
    else $error("remote 2 magnitude not stored");
  offset_reset_a: assert property (!seen_q
    |-> local_temp_offset_q == TOFR_RST_OFS && remote1_temp_offset_q == TOFR_RST_OFS
    && remote2_temp_offset_q == TOFR_RST_OFS)
    else $error("offset registers not zero after reset");

endmodule
`default_nettype wire
